// ### spi_angle_frames.sv
// Angle sensor SPI peripheral: readout, register read and write frames
`timescale 1ns/1ps
`default_nettype none
`include "spi_frames_cfg.svh"
module spi_angle_frames (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic SYS_RST_I,
	// SPI pins to and from the host
	input wire logic SCLK_I,
	input wire logic CS_N_I,
	input wire logic COPI_I,
	output logic CIPO_O,
	output logic CIPO_OE_O,
	// Sensor data
	input wire logic [15:0] ANGLE_I,
	input wire logic [15:0] TURNS_I,
	input wire logic [15:0] SPEED_I,
	// Sample stream handshake
	input wire logic SAMPLE_VALID_I,
	output logic SAMPLE_READY_O,
	// Configuration outputs
	output logic CCW_POSITIVE_O,
	output logic TURN_SPEED_SEL_O
);
	// ==========================================================
	// Pin synchronisers
	logic [2:0] sync1_r, sync2_r;
	logic sclk_d_r, cs_d_r;
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			// Idle pin levels, so no false edge follows reset
			sync1_r <= 3'h2;
			sync2_r <= 3'h2;
			sclk_d_r <= 1'b0;
			cs_d_r <= 1'b1;
		end else begin
			sync1_r <= {SCLK_I, CS_N_I, COPI_I};
			sync2_r <= sync1_r;
			sclk_d_r <= sync2_r[2];
			cs_d_r <= sync2_r[1];
		end
	end
	// Synchronised levels and edges
	wire sclk_s = sync2_r[2];
	wire cs_s = sync2_r[1];
	wire copi_s = sync2_r[0];
	wire sclk_rise = sclk_s & ~sclk_d_r;
	wire sclk_fall = ~sclk_s & sclk_d_r;
	wire cs_fall = ~cs_s & cs_d_r;
	wire cs_rise = cs_s & ~cs_d_r;
	// ==========================================================
	// Two-entry sample buffer
	logic [15:0] buf0_r, buf1_r, buf0_nxt, buf1_nxt;
	logic [15:0] trn0_r, trn1_r, trn0_nxt, trn1_nxt;
	logic [15:0] spd0_r, spd1_r, spd0_nxt, spd1_nxt;
	logic [1:0] cnt_r, cnt_nxt;
	logic [15:0] out_ang_r, out_ang_nxt; // Output buffer
	logic [15:0] out_trn_r, out_trn_nxt;
	logic [15:0] out_spd_r, out_spd_nxt;
	logic [`REFRESH_CNT_W-1:0] ref_r, ref_nxt;
	logic frozen_r, frozen_nxt;
	logic push, pop, ready_nxt;
	// Refresh tick drains buffer into output buffer unless frozen
	always_comb begin
		ref_nxt = ref_r + 1'b1;
		if (ref_r == `REFRESH_CNT_W'(`REFRESH_CYC - 1)) begin
			ref_nxt = '0;
		end
		frozen_nxt = frozen_r;
		if (cs_fall) begin
			frozen_nxt = 1'b1;
		end else if (cs_rise) begin
			frozen_nxt = 1'b0;
		end
		// Stall drains while frozen, so the buffer fills
		pop = (ref_r == '0) && !frozen_r && !cs_fall && (cnt_r != 2'h0);
		// Take a sample only while ready is shown, as the handshake promises
		push = SAMPLE_VALID_I && SAMPLE_READY_O;
		buf0_nxt = buf0_r;
		buf1_nxt = buf1_r;
		trn0_nxt = trn0_r;
		trn1_nxt = trn1_r;
		spd0_nxt = spd0_r;
		spd1_nxt = spd1_r;
		cnt_nxt = cnt_r;
		out_ang_nxt = out_ang_r;
		out_trn_nxt = out_trn_r;
		out_spd_nxt = out_spd_r;
		if (pop) begin
			out_ang_nxt = buf0_r;
			out_trn_nxt = trn0_r;
			out_spd_nxt = spd0_r;
			buf0_nxt = buf1_r;
			trn0_nxt = trn1_r;
			spd0_nxt = spd1_r;
		end
		if (push) begin
			if ((pop ? cnt_r - 2'h1 : cnt_r) == 2'h0) begin
				buf0_nxt = ANGLE_I;
				trn0_nxt = TURNS_I;
				spd0_nxt = SPEED_I;
			end else begin
				buf1_nxt = ANGLE_I;
				trn1_nxt = TURNS_I;
				spd1_nxt = SPEED_I;
			end
		end
		cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
		ready_nxt = (cnt_nxt != 2'h2); // Low only when both entries hold data
	end
	// Buffer registers
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			buf0_r <= 16'h0000;
			buf1_r <= 16'h0000;
			trn0_r <= 16'h0000;
			trn1_r <= 16'h0000;
			spd0_r <= 16'h0000;
			spd1_r <= 16'h0000;
			cnt_r <= 2'h0;
			out_ang_r <= 16'h0000;
			out_trn_r <= 16'h0000;
			out_spd_r <= 16'h0000;
			ref_r <= '0;
			frozen_r <= 1'b0;
			SAMPLE_READY_O <= 1'b0;
		end else begin
			buf0_r <= buf0_nxt;
			buf1_r <= buf1_nxt;
			trn0_r <= trn0_nxt;
			trn1_r <= trn1_nxt;
			spd0_r <= spd0_nxt;
			spd1_r <= spd1_nxt;
			cnt_r <= cnt_nxt;
			out_ang_r <= out_ang_nxt;
			out_trn_r <= out_trn_nxt;
			out_spd_r <= out_spd_nxt;
			ref_r <= ref_nxt;
			frozen_r <= frozen_nxt;
			SAMPLE_READY_O <= ready_nxt;
		end
	end
	// ==========================================================
	// Shift engine and frame sequencer
	logic [5:0] bits_r, bits_nxt; // Rising edges this frame
	logic [15:0] rx_r, rx_nxt;
	logic [31:0] tx_r, tx_nxt;
	logic cipo_r, cipo_nxt;
	logic oe_r, oe_nxt;
	logic [7:0] addr_r, addr_nxt;
	logic [7:0] echo_r, echo_nxt;
	logic wr_en;
	logic [7:0] rd_data;
	logic ccw_r, ccw_nxt, tsel_r, tsel_nxt;
	spi_frames_pkg::seq_t seq_r, seq_nxt;
	// Second word by selection bit
	function automatic logic [15:0] second_word(input logic sel, input logic [15:0] t,
		input logic [15:0] s);
		second_word = sel ? s : t;
	endfunction : second_word
	// Next shift state; mode 0 and 3 both capture on rise, drive on fall
	always_comb begin
		bits_nxt = bits_r;
		rx_nxt = rx_r;
		tx_nxt = tx_r;
		cipo_nxt = cipo_r;
		oe_nxt = oe_r;
		seq_nxt = seq_r;
		addr_nxt = addr_r;
		echo_nxt = echo_r;
		ccw_nxt = ccw_r;
		tsel_nxt = tsel_r;
		wr_en = 1'b0;
		if (cs_fall) begin
			bits_nxt = 6'h00;
			oe_nxt = 1'b1;
			case (seq_r)
				spi_frames_pkg::SEQ_RD2: tx_nxt = {out_ang_nxt[15:8], rd_data, 16'h0000};
				spi_frames_pkg::SEQ_WR3: tx_nxt = {out_ang_nxt[15:8], echo_r, 16'h0000};
				spi_frames_pkg::SEQ_WR2: tx_nxt = 32'h00000000; // Undefined frame
				default: tx_nxt = {out_ang_nxt, second_word(tsel_r, out_trn_nxt, out_spd_nxt)};
			endcase
			cipo_nxt = tx_nxt[31]; // MSB first
		end else if (!cs_s) begin
			if (sclk_rise) begin
				rx_nxt = {rx_r[14:0], copi_s};
				bits_nxt = (bits_r == 6'h3F) ? bits_r : bits_r + 6'h01;
			end
			if (sclk_fall && bits_r != 6'h00) begin
				tx_nxt = {tx_r[30:0], 1'b0};
				cipo_nxt = tx_r[30]; // Partial reads simply stop here
			end
		end
		if (cs_rise) begin
			oe_nxt = 1'b0;
			if (bits_r == `FRAME_BITS) begin
				case (seq_r)
					spi_frames_pkg::SEQ_IDLE: begin
						if (rx_r[15:8] == `CMD_READ) begin
							addr_nxt = rx_r[7:0];
							seq_nxt = spi_frames_pkg::SEQ_RD2;
						end else if (rx_r == `CMD_WRITE) begin
							seq_nxt = spi_frames_pkg::SEQ_WR2;
						end
					end
					spi_frames_pkg::SEQ_WR2: begin
						wr_en = 1'b1; // Full second frame seen
						addr_nxt = rx_r[15:8];
						echo_nxt = rx_r[7:0];
						if (rx_r[15:8] == `REG_DIR) begin
							ccw_nxt = rx_r[`DIR_BIT];
						end
						if (rx_r[15:8] == `REG_TURN_SPEED) begin
							tsel_nxt = rx_r[`TURN_SPEED_BIT];
						end
						seq_nxt = spi_frames_pkg::SEQ_WR3;
					end
					default: seq_nxt = spi_frames_pkg::SEQ_IDLE;
				endcase
			end else if (bits_r != 6'h00) begin
				seq_nxt = spi_frames_pkg::SEQ_IDLE; // Truncated frame aborts
			end
		end
	end
	// Shift registers
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			bits_r <= 6'h00;
			rx_r <= 16'h0000;
			tx_r <= 32'h00000000;
			cipo_r <= 1'b0;
			oe_r <= 1'b0;
			seq_r <= spi_frames_pkg::SEQ_IDLE;
			addr_r <= 8'h00;
			echo_r <= 8'h00;
			ccw_r <= 1'b0;
			tsel_r <= 1'b0;
		end else begin
			bits_r <= bits_nxt;
			rx_r <= rx_nxt;
			tx_r <= tx_nxt;
			cipo_r <= cipo_nxt;
			oe_r <= oe_nxt;
			seq_r <= seq_nxt;
			addr_r <= addr_nxt;
			echo_r <= echo_nxt;
			ccw_r <= ccw_nxt;
			tsel_r <= tsel_nxt;
		end
	end
	// Register store, read address held across frames
	cfg_regmem u_regmem (
		.clk_i(CLK_I),
		.wr_en_i(wr_en),
		.wr_addr_i(rx_r[8+`REG_ADDR_W-1:8]),
		.wr_data_i(rx_r[7:0]),
		.rd_addr_i(addr_r[`REG_ADDR_W-1:0]),
		.rd_data_o(rd_data)
	);
	// Registered outputs
	assign CIPO_O = cipo_r;
	assign CIPO_OE_O = oe_r;
	assign CCW_POSITIVE_O = ccw_r;
	assign TURN_SPEED_SEL_O = tsel_r;
endmodule : spi_angle_frames
`default_nettype wire

// ### spi_frames_cfg.svh
// Constants for the angle sensor SPI frame logic
`ifndef SPI_FRAMES_CFG_SVH
`define SPI_FRAMES_CFG_SVH
// ==========================================================
// Timing
`define CLK_FREQ_MHZ 100
`define REFRESH_NS 1250
`define REFRESH_CYC ((`REFRESH_NS * `CLK_FREQ_MHZ) / 1000)
`define REFRESH_CNT_W 8
// ==========================================================
// Frame decoding
`define FRAME_BITS 6'h10
`define CMD_READ 8'hD2
`define CMD_WRITE 16'hEA54
`define REG_DIR 8'h09
`define REG_TURN_SPEED 8'h1C
`define DIR_BIT 0
`define TURN_SPEED_BIT 7
`define REG_COUNT 64
`define REG_ADDR_W 6
`endif

// ### spi_frames_pkg.sv
// Types for the angle sensor SPI frame logic
`default_nettype none
package spi_frames_pkg;
	// Frame sequencing, Gray coded along the read path; the write path steps from SEQ_IDLE to SEQ_WR2 in two bits
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_RD2 = 2'b01,
		SEQ_WR2 = 2'b11,
		SEQ_WR3 = 2'b10
	} seq_t;
endpackage : spi_frames_pkg
`default_nettype wire

// ### cfg_regmem.sv
// Configuration register memory with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "spi_frames_cfg.svh"
module cfg_regmem (
	// Clock
	input wire logic clk_i,
	// Write port
	input wire logic wr_en_i,
	input wire logic [`REG_ADDR_W-1:0] wr_addr_i,
	input wire logic [7:0] wr_data_i,
	// Read port
	input wire logic [`REG_ADDR_W-1:0] rd_addr_i,
	output logic [7:0] rd_data_o
);
	// Storage array; no reset so it maps onto RAM
	logic [7:0] mem [0:`REG_COUNT-1];
	// Write and registered read
	always_ff @(posedge clk_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
		rd_data_o <= mem[rd_addr_i];
	end
	// Known power-up contents for simulation and FPGA init
	initial begin
		for (int i = 0; i < `REG_COUNT; i++) begin
			mem[i] = 8'h00;
		end
	end
endmodule : cfg_regmem
`default_nettype wire

// ### spi_frames_sva.sv
// Port checker for the angle sensor SPI frame block
`timescale 1ns/1ps
`default_nettype none
module spi_frames_sva (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic SYS_RST_I,
	// SPI pins
	input wire logic SCLK_I,
	input wire logic CS_N_I,
	input wire logic COPI_I,
	input wire logic CIPO_O,
	input wire logic CIPO_OE_O,
	// Sample stream
	input wire logic [15:0] ANGLE_I,
	input wire logic [15:0] TURNS_I,
	input wire logic [15:0] SPEED_I,
	input wire logic SAMPLE_VALID_I,
	input wire logic SAMPLE_READY_O,
	// Configuration
	input wire logic CCW_POSITIVE_O,
	input wire logic TURN_SPEED_SEL_O
);
	// ==========
	// Assertions, three cycles of pin sync allowed
	default clocking @(posedge CLK_I); endclocking
	default disable iff (SYS_RST_I);
	oe_idle_a: assert property (CS_N_I [*6] |-> !CIPO_OE_O)
		else $error("output enabled while idle");
	oe_sel_a: assert property ((!CS_N_I) [*5] |-> CIPO_OE_O)
		else $error("output off while selected");
	oe_rise_a: assert property ($fell(CS_N_I) |-> ##[2:5] CIPO_OE_O)
		else $error("output late after select");
	oe_fall_a: assert property ($rose(CS_N_I) |-> ##[2:5] !CIPO_OE_O)
		else $error("output held after release");
	// Drain runs once per refresh while not frozen
	ready_back_a: assert property ((CS_N_I && !SAMPLE_READY_O) |->
		##[1:300] (SAMPLE_READY_O || !CS_N_I))
		else $error("buffer never drains");
	cipo_hold_a: assert property ((!CS_N_I && $stable(SCLK_I)) [*6] |-> $stable(CIPO_O))
		else $error("data moved without clock");
	// Writes land only after a whole frame, so never mid-frame
	ccw_hold_a: assert property ($changed(CCW_POSITIVE_O) |-> CS_N_I)
		else $error("direction changed in frame");
	tsel_hold_a: assert property ($changed(TURN_SPEED_SEL_O) |-> CS_N_I)
		else $error("select changed in frame");
endmodule : spi_frames_sva
`default_nettype wire

// ### spi_host_model.sv
// Host SPI controller model for the angle sensor block
`timescale 1ns/1ps
`default_nettype none
module spi_host_model #(
	parameter int HALF = 8 // Half period, 160 ns clock
) (
	input wire logic clk_i,
	input wire logic cipo_i,
	output logic sclk_o,
	output logic cs_n_o,
	output logic copi_o
);
	logic mode3_r = 1'b0; // Idle level high in mode 3
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		copi_o = 1'b0;
	end
	// Clock stands at idle level between frames
	task automatic set_mode(input logic m);
		mode3_r = m;
		sclk_o <= m;
		repeat (HALF) @(posedge clk_i);
	endtask : set_mode
	// One framed transfer, MSB first; short counts end early
	task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
		rx = '0;
		cs_n_o <= 1'b0;
		repeat (HALF) @(posedge clk_i);
		for (int i = n - 1; i >= 0; i--) begin
			if (i < n - 1 || mode3_r) begin
				sclk_o <= 1'b0;
			end
			copi_o <= tx[i];
			repeat (HALF) @(posedge clk_i);
			sclk_o <= 1'b1;
			rx = {rx[30:0], cipo_i};
			repeat (HALF) @(posedge clk_i);
		end
		if (!mode3_r) begin
			sclk_o <= 1'b0;
			repeat (HALF) @(posedge clk_i);
		end
		cs_n_o <= 1'b1;
		copi_o <= ~copi_o; // Released line, no stale value
		repeat (16) @(posedge clk_i);
	endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// ### spi_angle_frames_test.sv
// Testbench for the angle sensor SPI frame block
`timescale 1ns/1ps
`default_nettype none
module spi_angle_frames_test;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [15:0] ang = '0;
	logic [15:0] trn = '0;
	logic [15:0] spd = '0;
	logic vld = 1'b0;
	wire logic sclk, cs_n, copi, cipo, oe, rdy, ccw, tsel, cipo_bus;
	// Released line reads inverted, so a late enable shows up as bad data
	assign cipo_bus = oe ? cipo : ~cipo;
	logic [15:0] cur = '0; // Angle now held in the output buffer
	int errors = 0;
	int check_count = 0;
	always #5 clk = ~clk;
	spi_angle_frames dut_u (.CLK_I(clk), .SYS_RST_I(rst), .SCLK_I(sclk), .CS_N_I(cs_n),
		.COPI_I(copi), .CIPO_O(cipo), .CIPO_OE_O(oe), .ANGLE_I(ang), .TURNS_I(trn),
		.SPEED_I(spd), .SAMPLE_VALID_I(vld), .SAMPLE_READY_O(rdy),
		.CCW_POSITIVE_O(ccw), .TURN_SPEED_SEL_O(tsel));
	spi_host_model #(.HALF(8)) host_u (.clk_i(clk), .cipo_i(cipo_bus), .sclk_o(sclk),
		.cs_n_o(cs_n), .copi_o(copi));
	// ==========
	// Shared tasks
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			errors++;
		end
	endtask : chk
	// Hold a sample until three refresh ticks have passed
	task automatic load(input logic [15:0] a, input logic [15:0] t, input logic [15:0] s);
		@(posedge clk);
		ang <= a;
		trn <= t;
		spd <= s;
		vld <= 1'b1;
		cur = a;
		repeat (400) @(posedge clk);
	endtask : load
	task automatic rd(input int n, input logic [31:0] tx, input logic [31:0] e, input string nm);
		logic [31:0] g;
		host_u.xfer(n, tx, g);
		chk(nm, e, g);
	endtask : rd
	task automatic wr_reg(input logic [7:0] ad, input logic [7:0] v);
		logic [31:0] g;
		rd(16, 32'hEA54, cur, "wr cmd");
		host_u.xfer(16, {ad, v}, g);
		rd(16, 0, {cur[15:8], v}, "wr echo");
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] ad, input logic [7:0] e);
		rd(16, {8'hD2, ad}, cur, "rd cmd");
		rd(16, 0, {cur[15:8], e}, "rd value");
	endtask : rd_reg
	task automatic report_and_stop;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : report_and_stop
	// ==========
	// Scenarios
	task automatic t_angle;
		logic [31:0] g;
		load(16'hA5C3, 16'h0123, 16'h4567);
		rd(16, 0, 32'hA5C3, "angle");
		host_u.xfer(16, 32'h00000000, g);
		chk("degrees", 32'h000000E9, (g * 32'h00000168) >> 16);
		rd(8, 0, 32'hA5, "partial");
		host_u.set_mode(1'b1);
		rd(16, 0, 32'hA5C3, "mode3 angle");
		host_u.set_mode(1'b0);
		$display("angle test done");
	endtask : t_angle
	// New input during a frame must not reach the frozen buffer
	task automatic t_freeze;
		ang <= 16'h3C5A;
		rd(16, 0, 32'hA5C3, "frozen");
		load(16'h3C5A, 16'h0123, 16'h4567);
		vld <= 1'b0;
		ang <= 16'hFFFF;
		rd(16, 0, 32'h3C5A, "repeat one");
		rd(16, 0, 32'h3C5A, "repeat two");
		$display("freeze test done");
	endtask : t_freeze
	task automatic t_regs;
		load(16'h5AA5, 16'h1357, 16'h2468);
		wr_reg(8'h09, 8'h01);
		chk("ccw", 1, ccw);
		rd_reg(8'h09, 8'h01);
		rd(16, 32'hEA54, cur, "wr cmd");
		// Cut frame would land a zero in register 9 if it were decoded
		rd(12, 32'h00000900, 32'h00000000, "cut frame");
		rd_reg(8'h09, 8'h01);
		rd_reg(8'h1C, 8'h00);
		chk("turn sel off", 0, tsel);
		rd(32, 0, {cur, 16'h1357}, "turns");
		wr_reg(8'h1C, 8'h80);
		chk("turn sel on", 1, tsel);
		rd(32, 0, {cur, 16'h2468}, "speed");
		$display("register test done");
	endtask : t_regs
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		t_angle();
		t_freeze();
		t_regs();
		report_and_stop();
	end
	initial begin
		repeat (50000) @(posedge clk);
		errors++;
		report_and_stop();
	end
endmodule : spi_angle_frames_test
bind spi_angle_frames spi_frames_sva chk_u (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
	.SCLK_I(SCLK_I), .CS_N_I(CS_N_I), .COPI_I(COPI_I), .CIPO_O(CIPO_O),
	.CIPO_OE_O(CIPO_OE_O), .ANGLE_I(ANGLE_I), .TURNS_I(TURNS_I), .SPEED_I(SPEED_I),
	.SAMPLE_VALID_I(SAMPLE_VALID_I), .SAMPLE_READY_O(SAMPLE_READY_O),
	.CCW_POSITIVE_O(CCW_POSITIVE_O), .TURN_SPEED_SEL_O(TURN_SPEED_SEL_O));
`default_nettype wire
